// file: common/charger_cfg.svh
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH
// Oscillator rate and prescaled tick
`define CLK_HZ 40000000
`define TICK_US 1000
`define TICK_CYC ((`CLK_HZ / 1000000) * `TICK_US)
// Timing figures in their own units
`define SAFETY_HOURS 6
`define QUAL_SINK_MS 32
`define QUAL_RETRY_MS 2000
`define SHORT_DEGLITCH_MS 1
// Derived tick counts (one tick is one millisecond)
`define SAFETY_TICKS (`SAFETY_HOURS * 3600 * 1000)
`define QUAL_SINK_TICKS (`QUAL_SINK_MS * 1000 / `TICK_US)
`define QUAL_RETRY_TICKS (`QUAL_RETRY_MS * 1000 / `TICK_US)
`define SHORT_DEGLITCH_TICKS (`SHORT_DEGLITCH_MS * 1000 / `TICK_US)
// Regulation adjustments
`define WARM_VREG_DROP_MV 140
`endif

// file: common/charger_pkg.sv
package charger_pkg;
  // Comparator results sampled from the analog front end
  typedef struct packed {
    logic above_undervoltage_lockout;
    logic above_sleep;
    logic above_weak;
    logic above_ovp;
    logic batt_short;
    logic batt_below_recharge;
    logic charge_done;
  } supply_cmp_t;

  // Thermal comparator results
  typedef struct packed {
    logic pack_below_hot;
    logic pack_below_warm;
    logic pack_above_cool;
    logic pack_above_cold;
    logic die_above_fold;
    logic die_above_shutdown;
    logic die_below_restart;
  } thermal_cmp_t;

  // Loop activity flags that decide when the safety timer slows
  typedef struct packed {
    logic fast_charge;
    logic sys_load_limit;
    logic input_floor_active;
  } loop_flags_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_QUAL_SINK,
    ST_QUAL_WAIT,
    ST_NORMAL,
    ST_SLEEP,
    ST_OVP,
    ST_TSD
  } sup_state_t;
endpackage

// file: design/charger_supervisory_fsm.sv
`timescale 1ns/100ps
`include "charger_cfg.svh"

module charger_supervisory_fsm #(
  parameter int unsigned TICK_CYC = `TICK_CYC,
  parameter int unsigned SAFETY_TICKS = `SAFETY_TICKS,
  parameter int unsigned QUAL_SINK_TICKS = `QUAL_SINK_TICKS,
  parameter int unsigned QUAL_RETRY_TICKS = `QUAL_RETRY_TICKS,
  parameter int unsigned DEGLITCH_TICKS = `SHORT_DEGLITCH_TICKS,
  parameter logic [7:0] VREG_DROP_MV = 8'(`WARM_VREG_DROP_MV)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire charger_pkg::supply_cmp_t supply_cmp,
  input wire charger_pkg::thermal_cmp_t thermal_cmp,
  input wire charger_pkg::loop_flags_t loop_flags,
  input wire logic charge_enable,
  input wire logic hiz_select,
  input wire logic floor_sense_pin,
  output logic converter_enable,
  output logic battery_fet_on,
  output logic discharge_fet_gate,
  output logic discharge_fet_gate_oe,
  output logic gate_drive_regulator,
  output logic test_sink_enable,
  output logic charging,
  output logic timer_fault,
  output logic half_current,
  output logic current_taper,
  output logic input_limit_reduce,
  output logic [7:0] vreg_drop_mv,
  output logic cycle_indicator_n_oe,
  output logic source_good_n_oe
);

  // Two-flop synchronisers for all pin and comparator inputs
  localparam int unsigned NIN = 24;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] meta_r;
  logic [NIN-1:0] sync_r;
  assign raw_in = {supply_cmp, thermal_cmp, loop_flags, charge_enable, hiz_select,
                   floor_sense_pin, 4'h0};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  charger_pkg::supply_cmp_t sup;
  charger_pkg::thermal_cmp_t thm;
  charger_pkg::loop_flags_t lp;
  logic ce_s;
  logic hiz_s;
  logic floor_s;
  assign sup = sync_r[23:17];
  assign thm = sync_r[16:10];
  assign lp = sync_r[9:7];
  assign ce_s = sync_r[6];
  assign hiz_s = sync_r[5];
  assign floor_s = sync_r[4];

  // Prescaled millisecond tick
  logic [31:0] pre_r;
  logic [31:0] pre_nxt;
  logic tick;
  always_comb begin
    tick = (pre_r == TICK_CYC - 1);
    pre_nxt = tick ? '0 : pre_r + 32'h1;
  end

  // Previous levels for toggle detection
  logic ce_q_r;
  logic hiz_q_r;
  logic pwr_q_r;
  logic toggle_evt;
  logic pwr_ok;
  assign pwr_ok = sup.above_undervoltage_lockout;
  assign toggle_evt = (ce_q_r != ce_s) || (hiz_q_r != hiz_s) || (pwr_ok && !pwr_q_r);

  // Main supervisory state
  charger_pkg::sup_state_t st_r;
  charger_pkg::sup_state_t st_nxt;
  charger_pkg::sup_state_t ovp_ret_r;
  charger_pkg::sup_state_t ovp_ret_nxt;
  logic [31:0] qcnt_r;
  logic [31:0] qcnt_nxt;
  logic [31:0] dcnt_r;
  logic [31:0] dcnt_nxt;
  logic short_off_r;
  logic short_off_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  logic half_r;
  logic half_nxt;
  logic fault_r;
  logic fault_nxt;
  logic chg_r;
  logic chg_nxt;
  logic ind_r;
  logic ind_nxt;
  logic new_cycle;
  logic indicated_cycle;
  logic therm_ok;
  logic slow;

  assign therm_ok = !thm.pack_below_hot && !thm.pack_above_cold;
  assign slow = lp.fast_charge && (lp.sys_load_limit || lp.input_floor_active
                || thm.die_above_fold);

  always_comb begin
    st_nxt = st_r;
    ovp_ret_nxt = ovp_ret_r;
    qcnt_nxt = qcnt_r;
    new_cycle = 1'b0;
    indicated_cycle = 1'b0;
    if (!pwr_ok) begin
      st_nxt = charger_pkg::ST_OFF;
    end else if (thm.die_above_shutdown && st_r != charger_pkg::ST_TSD) begin
      st_nxt = charger_pkg::ST_TSD;
    end else begin
      case (st_r)
        charger_pkg::ST_OFF: begin
          st_nxt = charger_pkg::ST_QUAL_SINK;
          qcnt_nxt = '0;
        end
        charger_pkg::ST_QUAL_SINK: begin
          if (!sup.above_weak) begin
            st_nxt = charger_pkg::ST_QUAL_WAIT;
            qcnt_nxt = '0;
          end else if (tick) begin
            if (qcnt_r >= QUAL_SINK_TICKS - 1) begin
              qcnt_nxt = '0;
              if (!sup.above_ovp) begin
                st_nxt = charger_pkg::ST_NORMAL;
                new_cycle = 1'b1;
                indicated_cycle = 1'b1;
              end
            end else begin
              qcnt_nxt = qcnt_r + 32'h1;
            end
          end
        end
        charger_pkg::ST_QUAL_WAIT: begin
          if (tick) begin
            if (qcnt_r >= QUAL_RETRY_TICKS - 1) begin
              st_nxt = charger_pkg::ST_QUAL_SINK;
              qcnt_nxt = '0;
            end else begin
              qcnt_nxt = qcnt_r + 32'h1;
            end
          end
        end
        charger_pkg::ST_NORMAL: begin
          if (sup.above_ovp) begin
            ovp_ret_nxt = st_r;
            st_nxt = charger_pkg::ST_OVP;
          end else if (!sup.above_sleep) begin
            st_nxt = charger_pkg::ST_SLEEP;
          end else if (!sup.above_weak) begin
            st_nxt = charger_pkg::ST_QUAL_SINK;
            qcnt_nxt = '0;
          end
        end
        charger_pkg::ST_SLEEP: begin
          if (sup.above_ovp) begin
            ovp_ret_nxt = st_r;
            st_nxt = charger_pkg::ST_OVP;
          end else if (sup.above_sleep) begin
            st_nxt = charger_pkg::ST_NORMAL;
            new_cycle = 1'b1;
          end
        end
        charger_pkg::ST_OVP: begin
          if (!sup.above_ovp) begin
            st_nxt = ovp_ret_r;
          end
        end
        charger_pkg::ST_TSD: begin
          if (thm.die_below_restart) begin
            st_nxt = charger_pkg::ST_NORMAL;
            new_cycle = 1'b1;
          end
        end
        default: st_nxt = charger_pkg::ST_OFF;
      endcase
    end
    // Enable, hiz or power toggle while running restarts the cycle
    if (st_r == charger_pkg::ST_NORMAL && toggle_evt) begin
      new_cycle = 1'b1;
      indicated_cycle = 1'b1;
    end
    // Automatic recharge carries no indicator
    if (st_r == charger_pkg::ST_NORMAL && !chg_r && !fault_r && sup.batt_below_recharge) begin
      new_cycle = 1'b1;
    end
  end

  // Charge cycle, safety timer and fault
  always_comb begin
    chg_nxt = chg_r;
    tmr_nxt = tmr_r;
    half_nxt = half_r;
    fault_nxt = fault_r;
    ind_nxt = ind_r;
    if (st_r == charger_pkg::ST_TSD || !pwr_ok) begin
      tmr_nxt = '0;
      chg_nxt = 1'b0;
    end
    if (!pwr_ok) begin
      ind_nxt = 1'b0;
    end
    if (new_cycle && !hiz_s && ce_s) begin
      chg_nxt = 1'b1;
      tmr_nxt = '0;
      half_nxt = 1'b0;
    end
    if (toggle_evt || !pwr_ok) begin
      fault_nxt = 1'b0;
    end
    if (indicated_cycle && !hiz_s && ce_s) begin
      ind_nxt = 1'b1;
    end
    if (chg_r && st_r == charger_pkg::ST_NORMAL) begin
      if (sup.charge_done || !ce_s || hiz_s) begin
        chg_nxt = 1'b0;
        ind_nxt = 1'b0;
      end else if (tick && therm_ok) begin
        half_nxt = !half_r;
        if (!slow || half_r) begin
          if (tmr_r >= SAFETY_TICKS - 1) begin
            chg_nxt = 1'b0;
            fault_nxt = 1'b1;
            ind_nxt = 1'b0;
          end else begin
            tmr_nxt = tmr_r + 32'h1;
          end
        end
      end
    end
  end

  // Battery-only short retest
  always_comb begin
    dcnt_nxt = dcnt_r;
    short_off_nxt = short_off_r;
    if (pwr_ok) begin
      short_off_nxt = 1'b0;
      dcnt_nxt = '0;
    end else if (!short_off_r && sup.batt_short) begin
      short_off_nxt = 1'b1;
      dcnt_nxt = '0;
    end else if (short_off_r && tick) begin
      if (dcnt_r >= DEGLITCH_TICKS - 1) begin
        short_off_nxt = 1'b0;
      end else begin
        dcnt_nxt = dcnt_r + 32'h1;
      end
    end
  end

  // Registered outputs
  logic run;
  logic susp;
  assign run = st_r == charger_pkg::ST_NORMAL;
  assign susp = !therm_ok || !chg_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_r <= '0;
      ce_q_r <= 1'b0;
      hiz_q_r <= 1'b0;
      pwr_q_r <= 1'b0;
      st_r <= charger_pkg::ST_OFF;
      ovp_ret_r <= charger_pkg::ST_NORMAL;
      qcnt_r <= '0;
      dcnt_r <= '0;
      short_off_r <= 1'b0;
      tmr_r <= '0;
      half_r <= 1'b0;
      fault_r <= 1'b0;
      chg_r <= 1'b0;
      ind_r <= 1'b0;
      converter_enable <= 1'b0;
      battery_fet_on <= 1'b0;
      discharge_fet_gate <= 1'b0;
      discharge_fet_gate_oe <= 1'b1;
      gate_drive_regulator <= 1'b0;
      test_sink_enable <= 1'b0;
      charging <= 1'b0;
      timer_fault <= 1'b0;
      half_current <= 1'b0;
      current_taper <= 1'b0;
      input_limit_reduce <= 1'b0;
      vreg_drop_mv <= 8'h00;
      cycle_indicator_n_oe <= 1'b1;
      source_good_n_oe <= 1'b1;
    end else begin
      pre_r <= pre_nxt;
      ce_q_r <= ce_s;
      hiz_q_r <= hiz_s;
      pwr_q_r <= pwr_ok;
      st_r <= st_nxt;
      ovp_ret_r <= ovp_ret_nxt;
      qcnt_r <= qcnt_nxt;
      dcnt_r <= dcnt_nxt;
      short_off_r <= short_off_nxt;
      tmr_r <= tmr_nxt;
      half_r <= half_nxt;
      fault_r <= fault_nxt;
      chg_r <= chg_nxt;
      ind_r <= ind_nxt;
      converter_enable <= run && !hiz_s;
      // FET on except during a timer fault while running, or a short on battery only
      battery_fet_on <= pwr_ok ? !(run && (fault_r || (susp && !chg_r && fault_r)))
                      : !short_off_r;
      discharge_fet_gate <= !run || hiz_s;
      discharge_fet_gate_oe <= !(!run || hiz_s);
      gate_drive_regulator <= pwr_ok && sup.above_sleep
                              && st_r != charger_pkg::ST_TSD;
      test_sink_enable <= st_r == charger_pkg::ST_QUAL_SINK;
      charging <= run && chg_r && therm_ok;
      timer_fault <= fault_r;
      half_current <= thm.pack_above_cool && !thm.pack_above_cold;
      current_taper <= thm.die_above_fold;
      input_limit_reduce <= run && floor_s;
      vreg_drop_mv <= (!thm.pack_below_hot && thm.pack_below_warm) ? VREG_DROP_MV
                      : 8'h00;
      cycle_indicator_n_oe <= !ind_r;
      source_good_n_oe <= !(pwr_ok && sup.above_sleep && !sup.above_ovp);
    end
  end

endmodule

// file: bench/supply_model.sv
`timescale 1ns/100ps
// Supply and pack as the device's comparators see them
module supply_model #(
  parameter int UNDERVOLTAGE_LOCKOUT = 3000, WEAK = 3400, OVP = 9000, SLP = 40,
  parameter int HOT = 30, WARM = 38, COOL = 52, COLD = 60,
  parameter int FOLD = 120, SHUT = 150, RST = 140
) (
  input wire logic clk,
  input var int vin,
  input var int vbat,
  input var int therm,
  input var int die,
  input wire logic short_i,
  input wire logic rch_i,
  input wire logic done_i,
  output charger_pkg::supply_cmp_t supply_cmp,
  output charger_pkg::thermal_cmp_t thermal_cmp
);
  // Levels move one cycle after the analog side, like a real comparator
  always_ff @(posedge clk) begin
    supply_cmp.above_undervoltage_lockout <= vin > UNDERVOLTAGE_LOCKOUT;
    supply_cmp.above_sleep <= vin > vbat + SLP;
    supply_cmp.above_weak <= vin > WEAK;
    supply_cmp.above_ovp <= vin > OVP;
    supply_cmp.batt_short <= short_i;
    supply_cmp.batt_below_recharge <= rch_i;
    supply_cmp.charge_done <= done_i;
    thermal_cmp.pack_below_hot <= therm < HOT;
    thermal_cmp.pack_below_warm <= therm < WARM;
    thermal_cmp.pack_above_cool <= therm > COOL;
    thermal_cmp.pack_above_cold <= therm > COLD;
    thermal_cmp.die_above_fold <= die > FOLD;
    thermal_cmp.die_above_shutdown <= die > SHUT;
    thermal_cmp.die_below_restart <= die < RST;
  end
endmodule

// file: bench/charger_fsm_chk_sva.sv
`timescale 1ns/100ps
// Causes other than in a_sink_alone are held six samples, enough to cover the input sync latency
module charger_fsm_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire charger_pkg::supply_cmp_t supply_cmp,
  input wire charger_pkg::thermal_cmp_t thermal_cmp,
  input wire logic floor_sense_pin,
  input wire logic converter_enable,
  input wire logic battery_fet_on,
  input wire logic discharge_fet_gate,
  input wire logic gate_drive_regulator,
  input wire logic test_sink_enable,
  input wire logic charging,
  input wire logic current_taper,
  input wire logic input_limit_reduce
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reg_off_low: assert property ((!supply_cmp.above_sleep) [*6] |-> !gate_drive_regulator)
    else $error("regulator on below sleep");
  a_tsd_stop: assert property (thermal_cmp.die_above_shutdown [*6] |->
    !converter_enable && !charging && !gate_drive_regulator) else $error("runs in shutdown");
  a_sleep_outs: assert property (
    (supply_cmp.above_undervoltage_lockout && !supply_cmp.above_sleep) [*6] |->
    !converter_enable && battery_fet_on && discharge_fet_gate) else $error("bad sleep outputs");
  a_ovp_stop: assert property (supply_cmp.above_ovp [*6] |->
    !converter_enable && !charging && battery_fet_on) else $error("runs in overvoltage");
  a_hot_freeze: assert property (thermal_cmp.pack_below_hot [*6] |-> !charging)
    else $error("charging while hot");
  a_sink_alone: assert property (test_sink_enable |-> !converter_enable)
    else $error("sink with converter");
  a_fold_taper: assert property (
    (thermal_cmp.die_above_fold && !thermal_cmp.die_above_shutdown) [*6] ##0 charging
    |-> current_taper) else $error("no taper");
  a_floor_cut: assert property (floor_sense_pin [*6] ##0 converter_enable |->
    input_limit_reduce) else $error("no input limit cut");
endmodule

// file: bench/testbench.sv
`timescale 1ns/100ps
// Charger supervisor against a steady-state model of its outputs
module testbench;
  localparam int TC = 4, ST = 200, QS = 4, QR = 8, DG = 2;
  localparam int UNDERVOLTAGE_LOCKOUT = 3000, WEAK = 3400, OVP = 9000, SLP = 40;
  localparam int HOT = 30, WARM = 38, COOL = 52, COLD = 60, SHUT = 150, FOLD = 120;
  localparam int CONV = 9, FET = 8, CHRG = 5, SINK = 2, FLT = 1, IND = 0;
  localparam logic [9:0] RST_OBS = 10'h009;
  logic clk;
  logic nrst = 1'b0;
  charger_pkg::supply_cmp_t supply_cmp;
  charger_pkg::thermal_cmp_t thermal_cmp;
  charger_pkg::loop_flags_t loop_flags;
  logic charge_enable, hiz_select, floor_sense_pin, short_i, rch_i, done_i;
  logic converter_enable, battery_fet_on, discharge_fet_gate, discharge_fet_gate_oe;
  logic gate_drive_regulator, test_sink_enable, charging, timer_fault, half_current;
  logic current_taper, input_limit_reduce, cycle_indicator_n_oe, source_good_n_oe;
  logic [7:0] vreg_drop_mv;
  logic [9:0] obs;
  int vin, vbat, therm, die, n, ex, fail_count, cmp_count;
  bit fault_e;
  int zq[$] = '{20, 34, 45, 56, 70};
  assign obs = {converter_enable, battery_fet_on, discharge_fet_gate, gate_drive_regulator,
    charging, half_current, source_good_n_oe, test_sink_enable, timer_fault,
    cycle_indicator_n_oe};

  charger_supervisory_fsm #(.TICK_CYC(TC), .SAFETY_TICKS(ST), .QUAL_SINK_TICKS(QS),
    .QUAL_RETRY_TICKS(QR), .DEGLITCH_TICKS(DG)) i_dut (.clk, .nrst, .supply_cmp,
    .thermal_cmp, .loop_flags, .charge_enable, .hiz_select, .floor_sense_pin,
    .converter_enable, .battery_fet_on, .discharge_fet_gate, .discharge_fet_gate_oe,
    .gate_drive_regulator, .test_sink_enable, .charging, .timer_fault, .half_current,
    .current_taper, .input_limit_reduce, .vreg_drop_mv, .cycle_indicator_n_oe,
    .source_good_n_oe);
  supply_model #(.UNDERVOLTAGE_LOCKOUT(UNDERVOLTAGE_LOCKOUT), .WEAK(WEAK), .OVP(OVP), .SLP(SLP), .HOT(HOT), .WARM(WARM),
    .COOL(COOL), .COLD(COLD), .SHUT(SHUT)) i_far (.clk, .vin, .vbat, .therm, .die, .short_i,
    .rch_i, .done_i, .supply_cmp, .thermal_cmp);

  // 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Samples on the falling edge so the design's updates have landed
  task automatic wait_bit(input int idx, input logic v, input int bound);
    n = 0;
    while (obs[idx] !== v) begin
      @(negedge clk);
      n++;
      if (n > bound) begin
        fail_count++;
        $display("wrong value at %0t: output %0d never settled", $time, idx);
        tally_and_finish();
      end
    end
  endtask

  // Steady outputs from the supply, pack and die levels plus the pins, done and the expected fault
  task automatic check_all();
    logic [6:0] e;
    bit sl, ok, sd, cw;
    sl = vin > UNDERVOLTAGE_LOCKOUT && vin > vbat + SLP;
    ok = sl && vin > WEAK && vin < OVP;
    sd = die > SHUT;
    cw = therm >= HOT && therm <= COLD;
    e[6] = ok && !hiz_select && !sd;
    e[5] = !fault_e;
    e[4] = hiz_select || !(sl && vin < OVP);
    e[3] = sl && !sd;
    e[2] = e[6] && charge_enable && cw && !fault_e && !done_i;
    e[1] = therm > COOL && therm <= COLD;
    e[0] = !(sl && vin < OVP);
    for (int i = 0; i < 7; i++) cmp_bit(obs[i + 3], e[i], "steady output");
    cmp_byte(vreg_drop_mv, (therm >= HOT && therm < WARM) ? 8'h8C : 8'h00, "reg drop");
    cmp_bit(discharge_fet_gate_oe, !e[4], "gate enable");
    cmp_bit(current_taper, die > FOLD, "taper");
    cmp_bit(input_limit_reduce, floor_sense_pin && ok && !sd, "input cut");
  endtask

  task automatic settle();
    repeat (40) @(negedge clk);
    check_all();
  endtask

  task automatic apply_vin(input int v);
    @(posedge clk);
    vin <= v;
    settle();
  endtask

  initial begin
    vin = 0;
    vbat = 3000;
    therm = 45;
    die = 25;
    {short_i, rch_i, done_i, fault_e} = 4'h0;
    {charge_enable, hiz_select, floor_sense_pin} = 3'h4;
    loop_flags = 3'h4;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(32'h3A0C));
    repeat (19) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < 10; i++) cmp_bit(obs[i], RST_OBS[i], "reset value");
    @(posedge clk);
    nrst <= 1'b1;
    // Source collapses under the test sink once, then qualifies
    @(posedge clk);
    vin <= 5000;
    wait_bit(SINK, 1'b1, 20);
    @(posedge clk);
    vin <= 3200;
    wait_bit(SINK, 1'b0, 10);
    repeat (10) @(posedge clk);
    vin <= 5000;
    wait_bit(SINK, 1'b1, 60);
    cmp_bit(n + 11 >= QR * TC - 4, 1'b1, "retry pause");
    wait_bit(CONV, 1'b1, 40);
    cmp_bit(n >= QS * TC - 4 && n <= QS * TC + 8, 1'b1, "sink time");
    settle();
    cmp_bit(obs[IND], 1'b0, "indicator");
    // Thermistor zones in random order
    for (int k = 0; k < 5; k++) begin
      n = $urandom % zq.size();
      @(posedge clk);
      therm <= zq[n];
      floor_sense_pin <= 1'($urandom);
      zq.delete(n);
      settle();
    end
    @(posedge clk);
    therm <= 45;
    apply_vin(3020);
    apply_vin(5000);
    apply_vin(9500);
    apply_vin(5000);
    @(posedge clk);
    vin <= 3200;
    wait_bit(CONV, 1'b0, 10);
    cmp_bit(obs[FET], 1'b1, "fet on weak");
    wait_bit(SINK, 1'b1, 60);
    @(posedge clk);
    vin <= 5000;
    wait_bit(CONV, 1'b1, 80);
    settle();
    @(posedge clk);
    hiz_select <= 1'b1;
    settle();
    @(posedge clk);
    hiz_select <= 1'b0;
    settle();
    cmp_bit(obs[IND], 1'b0, "indicator");
    @(posedge clk);
    done_i <= 1'b1;
    settle();
    cmp_bit(obs[IND], 1'b1, "indicator done");
    @(posedge clk);
    done_i <= 1'b0;
    rch_i <= 1'b1;
    settle();
    cmp_bit(obs[IND], 1'b1, "indicator recharge");
    // Battery only, shorted load
    @(posedge clk);
    {vin, rch_i, short_i} <= {32'h0, 2'h1};
    wait_bit(FET, 1'b0, 20);
    wait_bit(FET, 1'b1, 30);
    cmp_bit(n >= DG * TC - 3 && n <= DG * TC + 4, 1'b1, "deglitch");
    wait_bit(FET, 1'b0, 20);
    @(posedge clk);
    short_i <= 1'b0;
    settle();
    apply_vin(5000);
    // Safety timer: plain, three slowdowns, then plain again after a shutdown restarts it from zero
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      loop_flags <= {1'b1, k == 1, k == 2};
      die <= (k == 3) ? 125 : 25;
      charge_enable <= 1'b0;
      repeat (10) @(posedge clk);
      charge_enable <= 1'b1;
      fault_e = 1'b0;
      wait_bit(CHRG, 1'b1, 40);
      cmp_bit(obs[FLT], 1'b0, "fault cleared");
      if (k == 4) begin
        repeat (ST * TC / 2) @(posedge clk);
        die <= 155;
        wait_bit(CHRG, 1'b0, 20);
        @(posedge clk);
        die <= 145;
        repeat (30) @(negedge clk);
        cmp_bit(obs[CHRG], 1'b0, "restart too early");
        @(posedge clk);
        die <= 25;
        wait_bit(CHRG, 1'b1, 80);
      end
      ex = ST * TC * ((k % 4 != 0) ? 2 : 1);
      wait_bit(FLT, 1'b1, 2000);
      cmp_bit(n >= ex - 12 && n <= ex + 12, 1'b1, "timer length");
      fault_e = 1'b1;
      settle();
      cmp_bit(obs[IND], 1'b1, "indicator fault");
    end
    tally_and_finish();
  end
endmodule

bind charger_supervisory_fsm charger_fsm_chk i_chk (.clk, .nrst, .supply_cmp, .thermal_cmp,
  .floor_sense_pin, .converter_enable, .battery_fet_on, .discharge_fet_gate,
  .gate_drive_regulator, .test_sink_enable, .charging, .current_taper, .input_limit_reduce);
